// File: verilog/ast_tx_dev.sv
// Asynchronous serial transmitter with APB register slave
// Contract
// - Eight data bits, least significant first
// - One low start bit opens each character
// - One or two high stop bits close it
// - Optional even or odd parity after data
// - Software: parity only with multiprocessor mode off
// - Send only while transmit enable set; code gates only the start, a character under way still finishes
// - Empty flag 1 when holding register free
// - Software writes only when empty flag reads 1
// - Holding byte moves to shifter automatically
// - Transmit request raised while holding register free
// - Request asserts at once when enabled empty
// - Handler clears request after loading next byte
// - Ninth-bit mode only while select bit set
// - Software sets address mark before address bytes
// - Flow control bit decides if clear-to-send gates
// - Shared sixteen-bit baud generator and format
// - Driver enable output for external transceiver
// - Clear-to-send sampled one clock before character
// - Address mark sits between data and stop
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "ast_regs.svh"

module ast_tx_dev
  import ast_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             tx_irq,
  ast_link_if.dev          link
);

  if (BAUD_W < 2 || BAUD_W > 24) begin : g_chk
    $error("ast_tx_dev: BAUD_W out of range");
  end

  logic [`AST_C0_W-1:0] ctrl0;
  logic [`AST_C1_W-1:0] ctrl1;
  logic [BAUD_W-1:0]    baud_div;
  logic [BAUD_W-1:0]    baud_cnt;
  logic                 baud_tick;
  logic [7:0]           hold_data;
  logic                 hold_full;
  ast_state_t           state;
  logic [7:0]           shift;
  logic [2:0]           bit_idx;
  logic                 ninth_on;
  logic                 ninth_val;
  logic                 stop_two;
  logic                 stop_idx;
  logic                 cts_q;
  logic                 go;
  logic                 load;
  logic                 char_end;
  logic                 wr_en;
  logic                 addr_ok;
  logic [31:0]          rd_word;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Writes land at the access edge; pready is high in every access cycle
  assign wr_en = psel & penable & pready & pwrite;

  // Decode of mapped offsets
  always_comb begin
    case (paddr)
      `AST_OFF_TXDATA, `AST_OFF_CTRL0, `AST_OFF_CTRL1,
      `AST_OFF_STATUS, `AST_OFF_BAUD: addr_ok = 1'b1;
      default:                        addr_ok = 1'b0;
    endcase
  end

  // Read mux; transmit data reads back as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `AST_OFF_CTRL0: rd_word[`AST_C0_W-1:0] = ctrl0;
      `AST_OFF_CTRL1: rd_word[`AST_C1_W-1:0] = ctrl1;
      `AST_OFF_STATUS: begin
        rd_word[`AST_ST_EMPTY] = !hold_full;
        rd_word[`AST_ST_BUSY]  = (state != ast_idle);
        rd_word[`AST_ST_IRQ]   = tx_irq;
        rd_word[`AST_ST_CTS_N] = cts_q;
      end
      `AST_OFF_BAUD: rd_word[BAUD_W-1:0] = baud_div;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Answer registered in the setup cycle, so every access has zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & !penable;
      pslverr <= psel & !penable & !addr_ok;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // Control, format and baud registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0    <= `AST_C0_RESET;
      ctrl1    <= `AST_C1_RESET;
      baud_div <= BAUD_W'(`AST_BAUD_RESET);
    end else if (wr_en) begin
      case (paddr)
        `AST_OFF_CTRL0: ctrl0    <= pwdata[`AST_C0_W-1:0];
        `AST_OFF_CTRL1: ctrl1    <= pwdata[`AST_C1_W-1:0];
        `AST_OFF_BAUD:  baud_div <= pwdata[BAUD_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Holding register
  // ----------------------------------------------------------------
  // A write while still full is dropped rather than overwrite a byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_full <= 1'b0;
      hold_data <= 8'h00;
    end else if (load) begin
      hold_full <= 1'b0;  // Byte taken by the shifter
    end else if (wr_en && paddr == `AST_OFF_TXDATA && !hold_full) begin
      hold_full <= 1'b1;
      hold_data <= pwdata[7:0];
    end
  end

  // Request level follows the empty holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= ctrl0[`AST_C0_IRQ_EN] & !(hold_full | (wr_en && paddr == `AST_OFF_TXDATA));
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // One tick every baud_div+1 clocks; a receiver would share this tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= '0;
    end else if (baud_cnt == '0) begin
      baud_cnt <= baud_div;
    end else begin
      baud_cnt <= baud_cnt - 1'b1;
    end
  end

  assign baud_tick = (baud_cnt == '0);

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Clear-to-send registered so the decision uses last cycle's level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_q <= 1'b1;
    end else begin
      cts_q <= link.cts_n;
    end
  end

  // Start only when enabled, loaded and, if gated, cleared to send
  assign go = hold_full & ctrl0[`AST_C0_TX_EN]
            & (!ctrl0[`AST_C0_FC_EN] | !cts_q);
  assign char_end = (state == ast_stop) & baud_tick & (!stop_two | stop_idx);
  assign load = go & baud_tick & ((state == ast_idle) | char_end);

  // Shifter; format is latched at load so mid-character writes do no harm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ast_idle;
      shift     <= 8'h00;
      bit_idx   <= 3'h0;
      ninth_on  <= 1'b0;
      ninth_val <= 1'b0;
      stop_two  <= 1'b0;
      stop_idx  <= 1'b0;
      link.txd  <= 1'b1;
      link.line_driver_enable <= 1'b0;
    end else if (load) begin
      state     <= ast_start;
      shift     <= hold_data;
      bit_idx   <= 3'h0;
      ninth_on  <= ctrl1[`AST_C1_MP_EN] | ctrl0[`AST_C0_PAR_EN];
      ninth_val <= ctrl1[`AST_C1_MP_EN] ? ctrl1[`AST_C1_ADDR_MARK]
                 : (^hold_data ^ ctrl0[`AST_C0_PAR_ODD]);
      stop_two  <= ctrl0[`AST_C0_STOP2];
      stop_idx  <= 1'b0;
      link.txd  <= 1'b0;
      link.line_driver_enable <= 1'b1;
    end else if (baud_tick) begin  // Each bit lasts one tick period
      case (state)
        ast_start: begin
          link.txd <= shift[0];
          shift    <= {1'b0, shift[7:1]};
          state    <= ast_data;
        end
        ast_data: begin
          if (bit_idx == 3'h7) begin
            link.txd <= ninth_on ? ninth_val : 1'b1;
            state    <= ninth_on ? ast_ninth : ast_stop;
          end else begin
            link.txd <= shift[0];
            shift    <= {1'b0, shift[7:1]};
            bit_idx  <= bit_idx + 1'b1;
          end
        end
        ast_ninth: begin
          link.txd <= 1'b1;
          state    <= ast_stop;
        end
        ast_stop: begin
          link.txd <= 1'b1;
          if (stop_two && !stop_idx) begin
            stop_idx <= 1'b1;
          end else begin
            state   <= ast_idle;
            link.line_driver_enable <= 1'b0;
          end
        end
        ast_idle: link.txd <= 1'b1;
        default: begin
          state    <= ast_idle;
          link.txd <= 1'b1;
          link.line_driver_enable <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: verilog/ast_regs.svh
// Register offsets, field positions and reset values of the serial transmitter
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define AST_OFF_TXDATA    12'h000
`define AST_OFF_CTRL0     12'h004
`define AST_OFF_CTRL1     12'h008
`define AST_OFF_STATUS    12'h00c
`define AST_OFF_BAUD      12'h010

// ----------------------------------------------------------------
// Control 0 fields
// ----------------------------------------------------------------
`define AST_C0_TX_EN      0
`define AST_C0_RX_EN      1
`define AST_C0_PAR_EN     2
`define AST_C0_PAR_ODD    3
`define AST_C0_STOP2      4
`define AST_C0_FC_EN      5
`define AST_C0_IRQ_EN     6
`define AST_C0_W          7

// ----------------------------------------------------------------
// Control 1 and status fields
// ----------------------------------------------------------------
`define AST_C1_MP_EN      0
`define AST_C1_ADDR_MARK  1
`define AST_C1_W          2
`define AST_ST_EMPTY      0
`define AST_ST_BUSY       1
`define AST_ST_IRQ        2
`define AST_ST_CTS_N      3

// ----------------------------------------------------------------
// Reset values and data width
// ----------------------------------------------------------------
`define AST_C0_RESET      7'h00
`define AST_C1_RESET      2'h0
`define AST_BAUD_RESET    16'h0010
`define AST_DATA_BITS     8

`endif

// File: verilog/ast_pkg.sv
// Types shared by both ends of the serial link
package ast_pkg;

  // ----------------------------------------------------------------
  // One-hot frame states, used by transmitter and receiver alike
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ast_idle  = 5'h01,
    ast_start = 5'h02,
    ast_data  = 5'h04,
    ast_ninth = 5'h08,
    ast_stop  = 5'h10
  } ast_state_t;

endpackage

// File: verilog/ast_link_if.sv
// Serial line between the transmitter and the remote receiver
`timescale 1ns/1ps

interface ast_link_if;
  logic txd;                 // Serial data, idles high
  logic line_driver_enable;  // High while a character is on the line
  logic cts_n;               // Clear to send from the receiver, low means go

  modport dev (output txd, output line_driver_enable, input cts_n);
  modport far (input txd, input line_driver_enable, output cts_n);
endinterface

// File: verilog/ast_rx_end.sv
// Remote receiver end of the serial link
`timescale 1ns/1ps
`include "ast_regs.svh"

module ast_rx_end
  import ast_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  ast_link_if.far                link,
  input  wire logic [BAUD_W-1:0] baud_div,
  input  wire logic              ninth_en,
  input  wire logic              parity_check,
  input  wire logic              parity_odd,
  input  wire logic              rx_ready,
  output logic [7:0]             rx_data,
  output logic                   rx_ninth,
  output logic                   rx_valid,
  output logic                   frame_err,
  output logic                   parity_err
);

  if (BAUD_W < 2 || BAUD_W > 24) begin : g_chk
    $error("ast_rx_end: BAUD_W out of range");
  end

  ast_state_t        state;
  logic              line_q;
  logic              line_prev;
  logic [BAUD_W-1:0] cnt;
  logic [2:0]        bit_idx;
  logic [7:0]        shift;
  logic              ninth_q;
  logic              done;
  logic              stop_ok;
  logic              sample;

  assign sample = (cnt == '0);

  // ----------------------------------------------------------------
  // Line sampling
  // ----------------------------------------------------------------
  // Register the line once; the edge detector looks at registered copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q    <= 1'b1;
      line_prev <= 1'b1;
    end else begin
      line_q    <= link.txd;
      line_prev <= line_q;
    end
  end

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  // Samples each bit at its middle: half a period after the falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ast_idle;
      cnt     <= '0;
      bit_idx <= 3'h0;
      shift   <= 8'h00;
      ninth_q <= 1'b0;
      done    <= 1'b0;
      stop_ok <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state != ast_idle) begin
        cnt <= sample ? baud_div : cnt - 1'b1;
      end
      case (state)
        ast_idle: begin
          if (line_prev && !line_q) begin
            cnt   <= baud_div >> 1;
            state <= ast_start;
          end
        end
        ast_start: begin
          if (sample) begin
            bit_idx <= 3'h0;
            state   <= line_q ? ast_idle : ast_data;  // Glitch, not a start bit
          end
        end
        ast_data: begin
          if (sample) begin
            shift   <= {line_q, shift[7:1]};  // LSB arrives first
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 3'h7) begin
              state <= ninth_en ? ast_ninth : ast_stop;
            end
          end
        end
        ast_ninth: begin
          if (sample) begin
            ninth_q <= line_q;
            state   <= ast_stop;
          end
        end
        ast_stop: begin
          if (sample) begin
            stop_ok <= line_q;
            done    <= 1'b1;
            state   <= ast_idle;
          end
        end
        default: state <= ast_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Delivery to the user side and flow control
  // ----------------------------------------------------------------
  // A new character wins over a same-cycle acknowledge; cts held off while full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data    <= 8'h00;
      rx_ninth   <= 1'b0;
      rx_valid   <= 1'b0;
      frame_err  <= 1'b0;
      parity_err <= 1'b0;
      link.cts_n <= 1'b0;
    end else begin
      if (done) begin
        rx_data    <= shift;
        rx_ninth   <= ninth_en & ninth_q;
        rx_valid   <= 1'b1;
        frame_err  <= !stop_ok;
        parity_err <= parity_check & ninth_en & (ninth_q != (^shift ^ parity_odd));
      end else if (rx_ready) begin
        rx_valid <= 1'b0;
      end
      link.cts_n <= done | (rx_valid & !rx_ready);  // Pause sender while full
    end
  end

endmodule

// File: verif/ast_link_props.sv
// Concurrent checks on the serial line between transmitter and receiver
`timescale 1ns/1ps

module ast_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic txd,
  input wire logic drv_en,
  input wire logic cts_n
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Bench programs a divider of 3, so every bit lasts 4 clocks
  logic [1:0] phase;
  logic [6:0] high_len;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bit phase, wrapping every 4 clocks, and driver-on length, saturating so long bursts stay sane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase    <= 2'h0;
      high_len <= 7'h00;
    end else if (!drv_en) begin
      phase    <= 2'h0;
      high_len <= 7'h00;
    end else begin
      phase <= phase + 2'h1;
      if (high_len != 7'h7f) high_len <= high_len + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence start_bit_s;
    (!txd) [*4];
  endsequence

  sequence stop_tail_s;
    $past(txd, 1) && $past(txd, 4);
  endsequence

  AST_IDLE_HIGH: assert property (!drv_en |-> txd)
    else $error("line low while driver off");
  AST_DRV_WITH_START: assert property ($rose(drv_en) |-> $fell(txd))
    else $error("driver enable rose without start edge");
  AST_FALL_NEEDS_DRV: assert property ($fell(txd) |-> drv_en)
    else $error("line fell with driver off");
  AST_START_LEN: assert property ($rose(drv_en) |-> start_bit_s)
    else $error("start bit shorter than one bit period");
  AST_BIT_EDGE: assert property (drv_en && $past(drv_en) && $changed(txd)
      |-> phase == 2'h0)
    else $error("line changed inside a bit period");
  AST_STOP_HIGH: assert property ($fell(drv_en) |-> stop_tail_s)
    else $error("last stop bit not high");
  AST_FRAME_ALIGN: assert property ($fell(drv_en) |-> phase == 2'h0)
    else $error("driver released mid bit");
  AST_FRAME_MIN: assert property ($fell(drv_en) |-> high_len >= 7'd40)
    else $error("character shorter than ten bits");

  cover property (drv_en && cts_n);
endmodule

// File: verif/testbench.sv
// Self-checking bench: APB master, transmitter and receiver joined by the link
`timescale 1ns/1ps
`include "ast_regs.svh"

module testbench;
  import ast_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_irq;
  logic        rx_ninth_en = 1'b0;
  logic        rx_par_chk = 1'b0;
  logic        rx_par_odd = 1'b0;
  logic        rx_ready = 1'b0;
  logic [7:0]  rx_data;
  logic        rx_ninth;
  logic        rx_valid;
  logic        frame_err;
  logic        parity_err;
  logic [31:0] rd_val;
  logic        rd_err;
  logic [7:0]  c0;
  logic [7:0]  c1;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [7:0]  t0 [6] = '{8'h01, 8'h11, 8'h05, 8'h0d, 8'h01, 8'h01};
  logic [7:0]  t1 [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01};
  logic [7:0]  td [6] = '{8'ha5, 8'h3c, 8'h07, 8'h07, 8'h81, 8'h42};

  always #2.5 pclk = ~pclk;

  ast_link_if ast_link_if_i ();

  ast_tx_dev #(.BAUD_W(16)) ast_tx_dev_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_irq(tx_irq), .link(ast_link_if_i.dev));

  ast_rx_end #(.BAUD_W(16)) ast_rx_end_i (
    .pclk(pclk), .presetn(presetn), .link(ast_link_if_i.far), .baud_div(16'h0003),
    .ninth_en(rx_ninth_en), .parity_check(rx_par_chk), .parity_odd(rx_par_odd),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_ninth(rx_ninth), .rx_valid(rx_valid),
    .frame_err(frame_err), .parity_err(parity_err));

  ast_link_props ast_link_props_i (
    .pclk(pclk), .presetn(presetn), .txd(ast_link_if_i.txd),
    .drv_en(ast_link_if_i.line_driver_enable), .cts_n(ast_link_if_i.cts_n));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  // Holds the request until pready is sampled high; bounded by the timeout
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val  = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rd_val);
    chk("pslverr", {31'h0, err}, {31'h0, rd_err});
  endtask

  // Receiver format follows the transmitter's, set before any frame starts
  task automatic cfg(input logic [7:0] a0, input logic [7:0] a1);
    c0 = a0;
    c1 = a1;
    rx_ninth_en <= a0[2] | a1[0];
    rx_par_chk  <= a0[2] & ~a1[0];
    rx_par_odd  <= a0[3];
    apb(1'b1, `AST_OFF_CTRL1, {24'h0, a1});
    apb(1'b1, `AST_OFF_CTRL0, {24'h0, a0});
  endtask

  task automatic ack_rx;
    rx_ready <= 1'b1;
    @(posedge pclk);
    rx_ready <= 1'b0;
  endtask

  // Waits for one character, checks its length and what the receiver got
  task automatic frame(input logic [7:0] d, input logic ack);
    int len;
    int w;
    logic n9;
    len = 0;
    w = 0;
    n9 = c1[0] ? c1[1] : (c0[2] & (^d ^ c0[3]));
    do begin
      @(posedge pclk);
      w++;
    end while (ast_link_if_i.line_driver_enable !== 1'b1 && w < 400);
    while (ast_link_if_i.line_driver_enable === 1'b1 && len < 400) begin
      len++;
      @(posedge pclk);
    end
    // Receiver hands the byte over after its first stop-bit sample, before the line goes idle in two-stop formats
    @(posedge pclk);
    chk("frame_len", 4 * (10 + (c0[2] | c1[0]) + c0[4]), len);
    chk("rx_valid", 32'h1, {31'h0, rx_valid});
    chk("rx_data", {24'h0, d}, {24'h0, rx_data});
    chk("rx_ninth", {31'h0, n9}, {31'h0, rx_ninth});
    chk("rx_errs", 32'h0, {30'h0, frame_err, parity_err});
    if (ack) ack_rx();
  endtask

  task automatic final_report;
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("tx_irq", 32'h0, {31'h0, tx_irq});
    rd(`AST_OFF_CTRL0, 32'h0, 1'b0);
    rd(`AST_OFF_CTRL1, 32'h0, 1'b0);
    rd(`AST_OFF_STATUS, 32'h1, 1'b0);
    rd(`AST_OFF_BAUD, 32'h10, 1'b0);
    rd(12'h014, 32'h0, 1'b1);
    apb(1'b1, `AST_OFF_BAUD, 32'h3);
    cfg(8'h40, 8'h00);
    repeat (2) @(posedge pclk);
    chk("tx_irq", 32'h1, {31'h0, tx_irq});
    apb(1'b1, `AST_OFF_TXDATA, 32'h5a);
    apb(1'b1, `AST_OFF_TXDATA, 32'h99);
    rd(`AST_OFF_STATUS, 32'h0, 1'b0);
    repeat (60) @(posedge pclk);
    chk("drv_en", 32'h0, {31'h0, ast_link_if_i.line_driver_enable});
    cfg(8'h41, 8'h00);
    frame(8'h5a, 1'b1);
    chk("tx_irq", 32'h1, {31'h0, tx_irq});
    repeat (60) @(posedge pclk);
    chk("drv_en", 32'h0, {31'h0, ast_link_if_i.line_driver_enable});
    // Six formats: plain, two stops, even, odd, address mark, data mark
    for (int i = 0; i < 6; i++) begin
      cfg(t0[i], t1[i]);
      apb(1'b1, `AST_OFF_TXDATA, {24'h0, td[i]});
      frame(td[i], 1'b1);
    end
    // Flow control on: a pending character keeps the next one waiting
    cfg(8'h21, 8'h00);
    apb(1'b1, `AST_OFF_TXDATA, 32'h11);
    frame(8'h11, 1'b0);
    apb(1'b1, `AST_OFF_TXDATA, 32'h22);
    repeat (60) @(posedge pclk);
    chk("drv_en", 32'h0, {31'h0, ast_link_if_i.line_driver_enable});
    rd(`AST_OFF_STATUS, 32'h8, 1'b0);
    ack_rx();
    frame(8'h22, 1'b0);
    // Flow control off: busy receiver no longer holds the line
    cfg(8'h01, 8'h00);
    apb(1'b1, `AST_OFF_TXDATA, 32'h33);
    frame(8'h33, 1'b1);
    final_report();
  end
endmodule
